// file: core/manr_regs.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: mac-side negotiation control/status and auxiliary status registers
// Assumes: negotiation engine, copper status and media link are same-clock
// Notes:   timeout default MSB comes from the strap level caught after reset
//////////////////////////////////////////////////////////////////////////////
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
module manr_regs #(
  parameter int TMO_STEP_CYC = manr_pkg::TMO_STEP_CYC
) (
  input  wire logic                   CLK_I,
  input  wire logic                   RST_N_I,
  input  wire logic                   SOFT_RST_I,
  input  wire logic                   STRAP_TMO_MSB_I,
  input  wire logic [4:0]             ADDR_I,
  input  wire logic [15:0]            WDATA_I,
  input  wire logic                   WR_I,
  input  wire logic                   RD_I,
  output logic      [15:0]            RDATA_O,
  input  wire logic                   MEDIA_LINK_I,
  input  wire logic                   MAC_AN_EN_I,
  input  wire logic                   MAC_AN_CAPABLE_I,
  input  wire logic                   MAC_LINK_I,
  input  wire logic                   MAC_AN_DONE_I,
  input  wire manr_pkg::manr_mac_adv_t MAC_ADV_I,
  input  wire manr_pkg::manr_cu_stat_t CU_STAT_I,
  output logic                        MAC_IF_EN_O,
  output logic                        MAC_AN_RESTART_O,
  output logic                        MAC_AUTOSENSE_O,
  output logic                        PSAVE_EN_O,
  output logic                        PSAVE_TMO_O
);

  manr_pkg::manr_cfg_t cfg_r;
  logic                strap_done_r;
  logic                media_link_r;
  logic                restart_r;
  logic                sw_restart;
  logic                link_chg;
  logic [31:0]         tmo_cnt_r;
  logic [2:0]          tmo_sec_r;
  logic [15:0]         mac_word;
  logic [15:0]         aux_word;
  logic                wr_mac;
  logic                wr_aux;

  assign wr_mac = WR_I && (ADDR_I == manr_pkg::ADDR_MAC_NEG);
  assign wr_aux = WR_I && (ADDR_I == manr_pkg::ADDR_AUX);

  ////////////////////////////////////////////////////////////////////////////
  // sticky configuration, hardware reset only
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cfg_r.interlock     <= manr_pkg::RST_INTERLOCK;
      cfg_r.restart_ilock <= manr_pkg::RST_RST_ILOCK;
      cfg_r.autosense     <= manr_pkg::RST_AUTOSENSE;
      cfg_r.psave_en      <= manr_pkg::RST_PSAVE;
      cfg_r.tmo_code      <= {1'b0, manr_pkg::RST_TMO_LSB};
      strap_done_r        <= 1'b0;
    end else begin
      // soft reset deliberately not used here
      if (!strap_done_r) begin
        cfg_r.tmo_code[1] <= STRAP_TMO_MSB_I;
        strap_done_r      <= 1'b1;
      end
      if (wr_mac) begin
        cfg_r.interlock     <= WDATA_I[manr_pkg::MAC_INTERLOCK];
        cfg_r.restart_ilock <= WDATA_I[manr_pkg::MAC_RST_ILOCK];
        cfg_r.autosense     <= WDATA_I[manr_pkg::MAC_AUTOSENSE];
      end
      if (wr_aux) begin
        cfg_r.psave_en    <= WDATA_I[manr_pkg::AUX_PSAVE];
        cfg_r.tmo_code    <= {WDATA_I[manr_pkg::AUX_TMO_MSB],
                              WDATA_I[manr_pkg::AUX_TMO_LSB]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // negotiation restart pulse
  assign sw_restart = wr_mac && WDATA_I[manr_pkg::MAC_RESTART];
  assign link_chg   = media_link_r != MEDIA_LINK_I;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      media_link_r <= 1'b0;
      restart_r    <= 1'b0;
    end else begin
      media_link_r <= MEDIA_LINK_I;
      restart_r    <= sw_restart || SOFT_RST_I
                      || (cfg_r.restart_ilock && link_chg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-save link status timeout, one-second steps
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tmo_cnt_r <= 32'h0000_0000;
      tmo_sec_r <= 3'h0;
    end else if (!cfg_r.psave_en || MEDIA_LINK_I) begin
      tmo_cnt_r <= 32'h0000_0000;
      tmo_sec_r <= 3'h0;
    end else if (tmo_sec_r <= {1'b0, cfg_r.tmo_code}) begin
      if (tmo_cnt_r == 32'(TMO_STEP_CYC - 1)) begin
        tmo_cnt_r <= 32'h0000_0000;
        tmo_sec_r <= tmo_sec_r + 3'h1;
      end else begin
        tmo_cnt_r <= tmo_cnt_r + 32'h0000_0001;
      end
    end
  end

  assign PSAVE_EN_O       = cfg_r.psave_en;
  assign PSAVE_TMO_O      = tmo_sec_r > {1'b0, cfg_r.tmo_code};
  assign MAC_AN_RESTART_O = restart_r;
  assign MAC_AUTOSENSE_O  = cfg_r.autosense && MAC_AN_EN_I;
  assign MAC_IF_EN_O      = !cfg_r.interlock || MEDIA_LINK_I;

  ////////////////////////////////////////////////////////////////////////////
  // read words; restart bit and reserved bits read zero
  always_comb begin
    mac_word = 16'h0000;
    mac_word[manr_pkg::MAC_INTERLOCK] = cfg_r.interlock;
    mac_word[manr_pkg::MAC_RST_ILOCK] = cfg_r.restart_ilock;
    mac_word[manr_pkg::MAC_AUTOSENSE] = cfg_r.autosense;
    mac_word[manr_pkg::MAC_RFLT_LSB+:2] = MAC_ADV_I.remote_fault;
    mac_word[manr_pkg::MAC_ASYM] = MAC_ADV_I.asym_pause;
    mac_word[manr_pkg::MAC_SYM]  = MAC_ADV_I.sym_pause;
    mac_word[manr_pkg::MAC_FDX]  = MAC_ADV_I.full_duplex;
    mac_word[manr_pkg::MAC_HDX]  = MAC_ADV_I.half_duplex;
    mac_word[manr_pkg::MAC_CAPABLE] = MAC_AN_CAPABLE_I;
    mac_word[manr_pkg::MAC_LINK] = MAC_LINK_I;
    mac_word[manr_pkg::MAC_DONE] = MAC_AN_DONE_I;
    aux_word = 16'h0000;
    aux_word[manr_pkg::AUX_AN_DONE] = CU_STAT_I.an_complete;
    aux_word[manr_pkg::AUX_AN_DIS]  = !CU_STAT_I.an_enable;
    aux_word[manr_pkg::AUX_XOVER]   = CU_STAT_I.crossover;
    aux_word[manr_pkg::AUX_CD_SWAP] = CU_STAT_I.cd_swap;
    aux_word[manr_pkg::AUX_POL_LSB+:4] = CU_STAT_I.polarity;
    aux_word[manr_pkg::AUX_TMO_MSB] = cfg_r.tmo_code[1];
    aux_word[manr_pkg::AUX_PSAVE]   = cfg_r.psave_en;
    aux_word[manr_pkg::AUX_FDX]     = CU_STAT_I.full_duplex_flag;
    aux_word[manr_pkg::AUX_SPD_LSB+:2] = CU_STAT_I.speed;
    aux_word[manr_pkg::AUX_TMO_LSB] = cfg_r.tmo_code[0];
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 16'h0000;
    end else if (RD_I) begin
      case (ADDR_I)
        manr_pkg::ADDR_MAC_NEG: RDATA_O <= mac_word;
        manr_pkg::ADDR_AUX:     RDATA_O <= aux_word;
        default:                RDATA_O <= 16'h0000;
      endcase
    end else begin
      RDATA_O <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_interlock;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (cfg_r.interlock && !MEDIA_LINK_I) |-> !MAC_IF_EN_O;
  endproperty
  a_interlock: assert property (p_interlock)
    else $error("mac interface enabled while media link down");

  property p_relink;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (cfg_r.restart_ilock && $changed(MEDIA_LINK_I)) |=> MAC_AN_RESTART_O;
  endproperty
  a_relink: assert property (p_relink)
    else $error("no restart after media link change");

  property p_no_relink;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (!cfg_r.restart_ilock && !wr_mac && !SOFT_RST_I) |=> !MAC_AN_RESTART_O;
  endproperty
  a_no_relink: assert property (p_no_relink)
    else $error("restart without cause");

  property p_swrestart;
    @(posedge CLK_I) disable iff (!RST_N_I)
      sw_restart |=> MAC_AN_RESTART_O ##1 (!MAC_AN_RESTART_O || $past(WR_I));
  endproperty
  a_swrestart: assert property (p_swrestart)
    else $error("software restart pulse wrong");

  property p_rd_restart_zero;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (RD_I && ADDR_I == manr_pkg::ADDR_MAC_NEG)
        |=> !RDATA_O[manr_pkg::MAC_RESTART] && RDATA_O[11:10] == 2'h0;
  endproperty
  a_rd_restart_zero: assert property (p_rd_restart_zero)
    else $error("restart or reserved bits read nonzero");

  property p_rd_link;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (RD_I && ADDR_I == manr_pkg::ADDR_MAC_NEG)
        |=> RDATA_O[manr_pkg::MAC_LINK] == $past(MAC_LINK_I);
  endproperty
  a_rd_link: assert property (p_rd_link)
    else $error("mac link bit mismatch");

  property p_rd_andis;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (RD_I && ADDR_I == manr_pkg::ADDR_AUX)
        |=> RDATA_O[manr_pkg::AUX_AN_DIS] != $past(CU_STAT_I.an_enable);
  endproperty
  a_rd_andis: assert property (p_rd_andis)
    else $error("negotiation disabled bit not inverted");

  property p_sticky;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (SOFT_RST_I && !WR_I && strap_done_r) |=> $stable(cfg_r);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("sticky field lost on soft reset");

  property p_psave_wr;
    @(posedge CLK_I) disable iff (!RST_N_I)
      wr_aux |=> PSAVE_EN_O == $past(WDATA_I[manr_pkg::AUX_PSAVE]);
  endproperty
  a_psave_wr: assert property (p_psave_wr)
    else $error("power save enable not written");

endmodule : manr_regs

// file: core/manr_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants and carriers for the mac negotiation and aux registers
// Assumes: 16-bit registers on a plain strobe port, one clock at 50 MHz
//////////////////////////////////////////////////////////////////////////////
package manr_pkg;

  localparam logic [4:0]  ADDR_MAC_NEG    = 5'h1B;
  localparam logic [4:0]  ADDR_AUX        = 5'h1C;

  localparam int          MAC_INTERLOCK   = 15;
  localparam int          MAC_RST_ILOCK   = 14;
  localparam int          MAC_AUTOSENSE   = 13;
  localparam int          MAC_RESTART     = 12;
  localparam int          MAC_RFLT_LSB    = 8;
  localparam int          MAC_ASYM        = 7;
  localparam int          MAC_SYM         = 6;
  localparam int          MAC_FDX         = 5;
  localparam int          MAC_HDX         = 4;
  localparam int          MAC_CAPABLE     = 3;
  localparam int          MAC_LINK        = 2;
  localparam int          MAC_DONE        = 1;

  localparam int          AUX_AN_DONE     = 15;
  localparam int          AUX_AN_DIS      = 14;
  localparam int          AUX_XOVER       = 13;
  localparam int          AUX_CD_SWAP     = 12;
  localparam int          AUX_POL_LSB     = 8;
  localparam int          AUX_TMO_MSB     = 7;
  localparam int          AUX_PSAVE       = 6;
  localparam int          AUX_FDX         = 5;
  localparam int          AUX_SPD_LSB     = 3;
  localparam int          AUX_TMO_LSB     = 2;

  localparam logic        RST_INTERLOCK   = 1'h0;
  localparam logic        RST_RST_ILOCK   = 1'h0;
  localparam logic        RST_AUTOSENSE   = 1'h0;
  localparam logic        RST_PSAVE       = 1'h0;
  localparam logic        RST_TMO_LSB     = 1'h0;

  localparam int          CLK_HZ          = 50_000_000;
  localparam int          TMO_STEP_S      = 1;
  localparam int          TMO_STEP_CYC    = CLK_HZ * TMO_STEP_S;

  typedef struct packed {
    logic [1:0] remote_fault;
    logic       asym_pause;
    logic       sym_pause;
    logic       full_duplex;
    logic       half_duplex;
  } manr_mac_adv_t;

  typedef struct packed {
    logic       an_complete;
    logic       an_enable;
    logic       crossover;
    logic       cd_swap;
    logic [3:0] polarity;
    logic       full_duplex_flag;
    logic [1:0] speed;
  } manr_cu_stat_t;

  typedef struct packed {
    logic       interlock;
    logic       restart_ilock;
    logic       autosense;
    logic       psave_en;
    logic [1:0] tmo_code;
  } manr_cfg_t;

endpackage : manr_pkg

// file: verification/manr_mac_model.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: behavioural mac on the far side of the serial mac interface
// Assumes: same clock as the register block
// Notes:   slow_i stretches the time to link; restart drops the link
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module manr_mac_model #(
  parameter int         FAST = 4,
  parameter int         SLOW = 40,
  parameter logic [5:0] ADV  = 6'h2D
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              restart_i,
  input  wire logic              if_en_i,
  input  wire logic              slow_i,
  output logic                   an_en_o,
  output logic                   capable_o,
  output logic                   link_o,
  output logic                   done_o,
  output manr_pkg::manr_mac_adv_t adv_o
);
  int cnt;

  assign an_en_o   = 1'h1;
  assign capable_o = done_o;
  assign adv_o     = ADV;

  // negotiation restarts from scratch whenever the phy asks or disables us
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= 0;
      link_o <= 1'h0;
      done_o <= 1'h0;
    end else if (restart_i || !if_en_i) begin
      cnt    <= 0;
      link_o <= 1'h0;
      done_o <= 1'h0;
    end else if (cnt < (slow_i ? SLOW : FAST)) begin
      cnt <= cnt + 1;
    end else begin
      link_o <= 1'h1;
      done_o <= 1'h1;
    end
  end
endmodule : manr_mac_model

// file: verification/tb_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: self-checking bench for the mac negotiation and aux registers
// Assumes: timeout step shortened to 10 cycles
// Notes:   expected words built from a shadow of the writable fields
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module tb_top;
  localparam int STEP = 10;
  logic                    clk = 1'h0, rst_n = 1'h0, soft_rst = 1'h0;
  logic                    strap = 1'h1, wr = 1'h0, rd = 1'h0;
  logic                    media = 1'h1, slow = 1'h0;
  logic [4:0]              addr = 5'h00;
  logic [15:0]             wdata = 16'h0000, rdata, r;
  logic                    an_en, cap, lnk, done, if_en, restart;
  logic                    autosense, psave, tmo;
  manr_pkg::manr_mac_adv_t adv;
  manr_pkg::manr_cu_stat_t cu = '0;
  manr_pkg::manr_cfg_t     cfg = '0;
  int                      failures = 0, comparisons = 0, pulses = 0, p;

  manr_regs #(.TMO_STEP_CYC(STEP)) i_dut (.CLK_I(clk), .RST_N_I(rst_n),
    .SOFT_RST_I(soft_rst), .STRAP_TMO_MSB_I(strap), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .MEDIA_LINK_I(media), .MAC_AN_EN_I(an_en), .MAC_AN_CAPABLE_I(cap),
    .MAC_LINK_I(lnk), .MAC_AN_DONE_I(done), .MAC_ADV_I(adv), .CU_STAT_I(cu),
    .MAC_IF_EN_O(if_en), .MAC_AN_RESTART_O(restart),
    .MAC_AUTOSENSE_O(autosense), .PSAVE_EN_O(psave), .PSAVE_TMO_O(tmo));
  manr_mac_model i_mac (.clk_i(clk), .rst_n_i(rst_n), .restart_i(restart),
    .if_en_i(if_en), .slow_i(slow), .an_en_o(an_en), .capable_o(cap),
    .link_o(lnk), .done_o(done), .adv_o(adv));

  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (restart === 1'h1) pulses <= pulses + 1;

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'h1;
    @(posedge clk); wr <= 1'h0;
  endtask : wr_reg
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk); addr <= a; rd <= 1'h1;
    @(posedge clk); rd <= 1'h0;
    #1 d = rdata;
  endtask : rd_reg
  function automatic logic [15:0] exp_mac();
    return {cfg.interlock, cfg.restart_ilock, cfg.autosense, 3'h0, adv,
            cap, lnk, done, 1'h0};
  endfunction : exp_mac
  function automatic logic [15:0] exp_aux();
    return {cu.an_complete, ~cu.an_enable, cu.crossover, cu.cd_swap,
            cu.polarity, cfg.tmo_code[1], cfg.psave_en, cu.full_duplex_flag,
            cu.speed, cfg.tmo_code[0], 2'h0};
  endfunction : exp_aux
  task automatic chk_both(input string what);
    rd_reg(manr_pkg::ADDR_MAC_NEG, r); chk(r, exp_mac(), what);
    rd_reg(manr_pkg::ADDR_AUX, r); chk(r, exp_aux(), what);
  endtask : chk_both
  task automatic summarize;
    $display("counts: %0d compared, %0d failed", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  initial begin
    #(20 * 3000);
    failures++;
    summarize;
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(2); rst_n <= 1'h1; cfg.tmo_code = {strap, 1'h0};
    cyc(60); chk_both("reset");
    rd_reg(5'h1D, r); chk(r, 16'h0000, "unmapped");
    $display("test reset done");
    p = pulses; wr_reg(manr_pkg::ADDR_MAC_NEG, 16'hFFFF);
    cfg.interlock = 1'h1; cfg.restart_ilock = 1'h1; cfg.autosense = 1'h1;
    cyc(3); chk(16'(pulses - p), 16'h0001, "restart");
    cyc(60); chk_both("all ones");
    chk({15'h0000, autosense}, {15'h0000, an_en}, "sense");
    $display("test write done");
    p = pulses; media <= 1'h0; cyc(3);
    chk({15'h0000, if_en}, 16'h0000, "interlock");
    media <= 1'h1; cyc(3);
    chk({15'h0000, if_en}, 16'h0001, "interlock");
    chk(16'(pulses - p), 16'h0002, "media restart");
    wr_reg(manr_pkg::ADDR_MAC_NEG, 16'h0000); cfg = '0;
    cfg.tmo_code = {strap, 1'h0};
    p = pulses; media <= 1'h0; cyc(3);
    chk({15'h0000, if_en}, 16'h0001, "no interlock");
    media <= 1'h1; cyc(3);
    chk(16'(pulses - p), 16'h0000, "no restart");
    $display("test interlock done");
    for (int i = 0; i < 4; i++) begin
      cu <= (i == 0) ? 11'h7FF : (i == 1) ? 11'h555 : (i == 2) ? 11'h2AA : 11'h000;
      cyc(2); rd_reg(manr_pkg::ADDR_AUX, r);
      chk(r, exp_aux(), "aux status");
    end
    cu <= 11'h5AA; cyc(2);
    rd_reg(manr_pkg::ADDR_AUX, r); chk(r, exp_aux(), "pairs");
    $display("test aux done");
    wr_reg(manr_pkg::ADDR_AUX, 16'hFFFF); cfg.tmo_code = 2'h3; cfg.psave_en = 1'h1;
    cyc(2); chk_both("aux ones");
    wr_reg(manr_pkg::ADDR_AUX, 16'h0044); cfg.tmo_code = 2'h1;
    cyc(1); chk({15'h0000, psave}, 16'h0001, "psave");
    media <= 1'h0; cyc(2 * STEP - 3);
    chk({15'h0000, tmo}, 16'h0000, "timeout early");
    cyc(6); chk({15'h0000, tmo}, 16'h0001, "timeout");
    media <= 1'h1; cyc(2); chk({15'h0000, tmo}, 16'h0000, "tmo clr");
    $display("test timeout done");
    wr_reg(manr_pkg::ADDR_MAC_NEG, 16'hE000);
    cfg.interlock = 1'h1; cfg.restart_ilock = 1'h1; cfg.autosense = 1'h1;
    slow <= 1'h1; soft_rst <= 1'h1; cyc(1); soft_rst <= 1'h0;
    cyc(60); chk_both("soft reset");
    strap <= 1'h0; rst_n <= 1'h0; cyc(2); rst_n <= 1'h1;
    cfg = '0; cyc(60); chk_both("hard reset");
    $display("test resets done");
    summarize;
  end
endmodule : tb_top
